/* File: jitter_pkg.sv */
`default_nettype none
package jitter_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CH    = 4;
    localparam int STORE_MAX = 128;
    localparam int PTR_W     = 7;
    localparam int CNT_W     = 8;
    localparam int ADDR_W    = 8;
    localparam int CFG_W     = 4;
    localparam int CFG_PATH  = 0;
    localparam int CFG_DLO   = 1;
    localparam int CFG_DHI   = 2;
    localparam int STATE_HOST = 31;

    // ==========================================================
    // Synchroniser vector layout
    localparam int SY_HOST  = 0;
    localparam int SY_PATH  = 1;
    localparam int SY_DLO   = 2;
    localparam int SY_DHI   = 3;
    localparam int TXC_BASE = 4;
    localparam int TXD_BASE = TXC_BASE + NUM_CH;
    localparam int RXC_BASE = TXD_BASE + NUM_CH;
    localparam int RXD_BASE = RXC_BASE + NUM_CH;
    localparam int DJC_BASE = RXD_BASE + NUM_CH;
    localparam int SYNC_W   = DJC_BASE + NUM_CH;

    // ==========================================================
    // Store sizes and limit margin
    localparam logic [CNT_W-1:0] SIZE_16      = 8'h10;
    localparam logic [CNT_W-1:0] SIZE_32      = 8'h20;
    localparam logic [CNT_W-1:0] SIZE_128     = 8'h80;
    localparam logic [CNT_W-1:0] LIMIT_MARGIN = 8'h02;

    // ==========================================================
    // Register offsets, reset values, responses
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT      = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATE      = 8'h14;
    localparam logic [31:0]       CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0]       INT_EN_RESET    = 32'h0000_0000;
    localparam logic [1:0]        RESP_OKAY       = 2'h0;
    localparam logic [1:0]        RESP_SLVERR     = 2'h2;

    // Depth select code {high, low}
    typedef enum logic [1:0] {DEPTH_OFF, DEPTH_16, DEPTH_32, DEPTH_128} depth_e;

    function automatic logic [CNT_W-1:0] store_size(input depth_e d);
        case (d)
            DEPTH_16:  store_size = SIZE_16;
            DEPTH_32:  store_size = SIZE_32;
            DEPTH_128: store_size = SIZE_128;
            default:   store_size = 8'h00;
        endcase
    endfunction : store_size
endpackage : jitter_pkg
`default_nettype wire

/* File: store_if.sv */
`default_nettype none
interface store_if;
    import jitter_pkg::*;
    logic   wr_en;
    logic   wr_bit;
    logic   rd_en;
    logic   clear;
    depth_e depth;
    logic   rd_bit;
    logic   near_limit;
    modport store (input wr_en, wr_bit, rd_en, clear, depth, output rd_bit, near_limit);
    modport ctrl  (output wr_en, wr_bit, rd_en, clear, depth, input rd_bit, near_limit);
endinterface : store_if
`default_nettype wire

/* File: jitter_store.sv */
`default_nettype none
module jitter_store (
    input wire logic aclk,
    input wire logic aresetn,
    store_if.store   sif
);
    import jitter_pkg::*;

    // ==========================================================
    // Storage and pointers
    logic                 mem_reg [STORE_MAX];
    logic [PTR_W-1:0]     wr_ptr_reg;
    logic [PTR_W-1:0]     rd_ptr_reg;
    logic [CNT_W-1:0]     fill_reg;
    logic [CNT_W-1:0]     size;
    logic [CNT_W-1:0]     half;
    logic                 full;
    logic                 empty;
    logic                 do_wr;
    logic                 do_rd;

    // Pointer step with wrap at the selected depth
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
                                                 input logic [CNT_W-1:0] sz);
        logic [CNT_W-1:0] nxt;
        nxt = {1'b0, p} + 8'h01;
        ptr_inc = (nxt >= sz) ? '0 : nxt[PTR_W-1:0];
    endfunction : ptr_inc

    assign size  = store_size(sif.depth);
    assign half  = {1'b0, size[CNT_W-1:1]};
    assign full  = fill_reg >= size;
    assign empty = fill_reg == 8'h00;
    // Overrun and underrun are dropped, never wrapped over live bits
    assign do_wr = sif.wr_en && !full;
    assign do_rd = sif.rd_en && !empty;

    always_ff @(posedge aclk) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg] <= sif.wr_bit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || sif.clear) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= half[PTR_W-1:0];
            fill_reg   <= half;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg, size);
            end
            if (do_rd) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg, size);
            end
            fill_reg <= fill_reg + {7'h00, do_wr} - {7'h00, do_rd};
        end
    end

    // Head bit is offered combinationally; the caller registers it
    assign sif.rd_bit = mem_reg[rd_ptr_reg];

    // within two bits of a limit
    assign sif.near_limit = (sif.depth != DEPTH_OFF) &&
                            ((fill_reg <= LIMIT_MARGIN) || (fill_reg + LIMIT_MARGIN >= size));

    // ==========================================================
    // Checks
    // write grows fill
    AST_WR_ADVANCE: assert property (@(posedge aclk) disable iff (!aresetn)
        (sif.wr_en && !full && !sif.rd_en && !sif.clear) |=> fill_reg == $past(fill_reg) + 8'h01)
        else $error("fill did not grow on write");
    AST_RESTART_HALF: assert property (@(posedge aclk) disable iff (!aresetn)
        sif.clear |=> (fill_reg == $past(half) && rd_ptr_reg == '0))
        else $error("store did not restart at half depth");
    AST_NEAR_OVER: assert property (@(posedge aclk) disable iff (!aresetn)
        (sif.depth != DEPTH_OFF && $stable(sif.depth) && do_wr && !do_rd && !sif.clear
         && fill_reg + LIMIT_MARGIN + 8'h01 == size) |=> sif.near_limit)
        else $error("near limit missed two bits from full");
    AST_DEPTH_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
        (sif.depth != DEPTH_OFF && $stable(sif.depth)) |-> fill_reg <= size)
        else $error("fill exceeds selected depth");
endmodule : jitter_store
`default_nettype wire

/* File: jitter_attenuator_fifo.sv */
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`default_nettype none
// Function
// - In host mode each channel's path bit puts its attenuator in the receive or transmit path.
// - In hardware mode one path pin puts all channels' attenuators in the same path.
// - The elastic store depth is selectable as 16, 32 or 128 bits.
// - In host mode a two-bit per-channel setting picks the depth or bypasses the attenuator.
// - In hardware mode two depth pins pick one depth for all channels or bypass them all.
// - Bits are written on the selected path's clock and read out on the dejittered clock.
// - Within two bits of overflow or underflow the channel's limit flag is set to 1.
// - Reading the limit flag clears that channel's store and returns the flag to default.
module jitter_attenuator_fifo (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite slave
    input  wire logic [jitter_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [jitter_pkg::ADDR_W-1:0] araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // Mode and hardware-mode pins
    input  wire logic                          host_mode_pin,
    input  wire logic                          jitter_path_select_pin,
    input  wire logic                          store_depth_select_low_pin,
    input  wire logic                          store_depth_select_high_pin,
    // Line-side streams, one bit per channel
    input  wire logic [jitter_pkg::NUM_CH-1:0] transmit_path_clock,
    input  wire logic [jitter_pkg::NUM_CH-1:0] transmit_data_in,
    input  wire logic [jitter_pkg::NUM_CH-1:0] receive_path_clock,
    input  wire logic [jitter_pkg::NUM_CH-1:0] receive_data_in,
    input  wire logic [jitter_pkg::NUM_CH-1:0] dejittered_clock,
    output logic [jitter_pkg::NUM_CH-1:0]      transmit_data_out,
    output logic [jitter_pkg::NUM_CH-1:0]      receive_data_out,
    output logic                               irq
);
    import jitter_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0]  pins;
    logic [SYNC_W-1:0]  s1_reg;
    logic [SYNC_W-1:0]  s2_reg;
    logic [SYNC_W-1:0]  s3_reg;
    logic [SYNC_W-1:0]  filt_reg;
    logic [SYNC_W-1:0]  rise;

    assign pins = {dejittered_clock, receive_data_in, receive_path_clock,
                   transmit_data_in, transmit_path_clock,
                   store_depth_select_high_pin, store_depth_select_low_pin,
                   jitter_path_select_pin, host_mode_pin};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A level counts only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_reg <= '0;
        end else begin
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
        end
    end

    assign rise = s2_reg & s3_reg & ~filt_reg;

    // ==========================================================
    // Register state
    logic [31:0]        ctrl_reg;
    logic [31:0]        int_en_reg;
    logic [NUM_CH-1:0]  int_status_reg;
    logic [NUM_CH-1:0]  limit_reg;
    logic [NUM_CH-1:0]  limit_next;
    logic [NUM_CH-1:0]  int_status_next;
    logic [3*NUM_CH-1:0] cfg_prev_reg;
    logic [3*NUM_CH-1:0] cfg_now;

    // ==========================================================
    // Effective configuration
    logic               host;
    logic [NUM_CH-1:0]  path_tx;
    logic [NUM_CH-1:0]  enabled;
    depth_e             depth_w [NUM_CH];

    assign host = filt_reg[SY_HOST];

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (host) begin
                path_tx[i] = ctrl_reg[i*CFG_W + CFG_PATH];
                depth_w[i] = depth_e'({ctrl_reg[i*CFG_W + CFG_DHI], ctrl_reg[i*CFG_W + CFG_DLO]});
            end else begin
                path_tx[i] = filt_reg[SY_PATH];
                depth_w[i] = depth_e'({filt_reg[SY_DHI], filt_reg[SY_DLO]});
            end
            enabled[i] = depth_w[i] != DEPTH_OFF;
            cfg_now[3*i +: 3] = {depth_w[i], path_tx[i]};
        end
    end

    // A change of path or depth restarts the store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_prev_reg <= '0;
        end else begin
            cfg_prev_reg <= cfg_now;
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    logic               aw_got_reg;
    logic [ADDR_W-1:0]  aw_addr_reg;
    logic               w_got_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;
    logic               wr_fire;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            old_v[8*b +: 8] = strb[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
        end
        apply_strb = old_v;
    endfunction : apply_strb

    // Address and data are taken in either order, then applied together
    assign awready = !aw_got_reg;
    assign wready  = !w_got_reg;
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_got_reg   <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_got_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end else if (wr_fire) begin
                w_got_reg <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only targets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            case (aw_addr_reg)
                ADDR_CTRL, ADDR_INT_CLEAR, ADDR_INT_ENABLE: bresp_reg <= RESP_OKAY;
                default:                                    bresp_reg <= RESP_SLVERR;
            endcase
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Writable control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= CTRL_RESET;
            int_en_reg <= INT_EN_RESET;
        end else if (wr_fire) begin
            if (aw_addr_reg == ADDR_CTRL) begin
                ctrl_reg <= apply_strb(ctrl_reg, w_data_reg, w_strb_reg);
            end
            if (aw_addr_reg == ADDR_INT_ENABLE) begin
                int_en_reg <= apply_strb(int_en_reg, w_data_reg, w_strb_reg);
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;
    logic               ar_fire;
    logic               rd_clr;
    logic [31:0]        rdata_next;
    logic [1:0]         rresp_next;

    assign arready = !rvalid_reg;
    assign ar_fire = arvalid && arready;
    assign rd_clr  = ar_fire && (araddr == ADDR_LIMIT);
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    // Read mux; the write-only clear register reads as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        rresp_next = RESP_OKAY;
        case (araddr)
            ADDR_CTRL:       rdata_next = ctrl_reg;
            ADDR_LIMIT:      rdata_next[NUM_CH-1:0] = limit_reg;
            ADDR_INT_STATUS: rdata_next[NUM_CH-1:0] = int_status_reg;
            ADDR_INT_CLEAR:  rdata_next = 32'h0000_0000;
            ADDR_INT_ENABLE: rdata_next = int_en_reg;
            ADDR_STATE: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    rdata_next[i*CFG_W +: 3] = cfg_now[3*i +: 3];
                end
                rdata_next[STATE_HOST] = host;
            end
            default:         rresp_next = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Per-channel elastic stores
    logic [NUM_CH-1:0]  near_w;
    logic [NUM_CH-1:0]  rd_bit_w;
    logic [NUM_CH-1:0]  clear_w;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        store_if sif ();

        // read of a set flag clears the store
        assign clear_w[ch] = (rd_clr && limit_reg[ch]) || !enabled[ch] ||
                             (cfg_now[3*ch +: 3] != cfg_prev_reg[3*ch +: 3]);
        assign sif.clear   = clear_w[ch];
        assign sif.depth   = depth_w[ch];
        assign sif.wr_en   = enabled[ch] && (path_tx[ch] ? rise[TXC_BASE + ch]
                                                         : rise[RXC_BASE + ch]);
        assign sif.wr_bit  = path_tx[ch] ? s3_reg[TXD_BASE + ch] : s3_reg[RXD_BASE + ch];
        assign sif.rd_en   = enabled[ch] && rise[DJC_BASE + ch];
        assign near_w[ch]  = sif.near_limit;
        assign rd_bit_w[ch] = sif.rd_bit;

        jitter_store u_store (
            .aclk    (aclk),
            .aresetn (aresetn),
            .sif     (sif)
        );
    end

    // ==========================================================
    // Line outputs: dejittered data in the chosen path, bypass otherwise
    logic [NUM_CH-1:0]  tx_out_reg;
    logic [NUM_CH-1:0]  rx_out_reg;
    logic [NUM_CH-1:0]  attn_tx;
    logic [NUM_CH-1:0]  attn_rx;

    assign attn_tx = path_tx & enabled;
    assign attn_rx = ~path_tx & enabled;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_out_reg <= '0;
            rx_out_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (attn_tx[i] ? rise[DJC_BASE + i] : rise[TXC_BASE + i]) begin
                    tx_out_reg[i] <= attn_tx[i] ? rd_bit_w[i] : s3_reg[TXD_BASE + i];
                end
                if (attn_rx[i] ? rise[DJC_BASE + i] : rise[RXC_BASE + i]) begin
                    rx_out_reg[i] <= attn_rx[i] ? rd_bit_w[i] : s3_reg[RXD_BASE + i];
                end
            end
        end
    end

    assign transmit_data_out = tx_out_reg;
    assign receive_data_out  = rx_out_reg;

    // ==========================================================
    // Limit flags and interrupt
    logic [NUM_CH-1:0]  lim_set;
    logic [NUM_CH-1:0]  int_clr;

    // A store being cleared this cycle does not re-arm its own flag
    assign lim_set = near_w & ~clear_w;
    assign int_clr = (wr_fire && aw_addr_reg == ADDR_INT_CLEAR) ?
                     w_data_reg[NUM_CH-1:0] : '0;

    // set flag; read clears, set wins
    assign limit_next      = lim_set | (limit_reg & ~{NUM_CH{rd_clr}});
    assign int_status_next = (lim_set & ~limit_reg) | (int_status_reg & ~int_clr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            limit_reg      <= '0;
            int_status_reg <= '0;
        end else begin
            limit_reg      <= limit_next;
            int_status_reg <= int_status_next;
        end
    end

    // Level interrupt while any enabled status bit stands
    assign irq = |(int_status_reg & int_en_reg[NUM_CH-1:0]);

    // ==========================================================
    // Checks
    // host write steers path
    AST_HOST_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && aw_addr_reg == ADDR_CTRL && w_strb_reg[0] && host && $stable(host))
        |=> path_tx[0] == $past(w_data_reg[CFG_PATH]))
        else $error("host path bit not applied");
    AST_HW_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
        !host |-> path_tx == {NUM_CH{filt_reg[SY_PATH]}})
        else $error("hardware path pin not common");
    AST_HW_DEPTH: assert property (@(posedge aclk) disable iff (!aresetn)
        (!host && !filt_reg[SY_DLO] && !filt_reg[SY_DHI]) |-> enabled == '0)
        else $error("hardware depth pins did not disable all");
    AST_BYPASS: assert property (@(posedge aclk) disable iff (!aresetn)
        (!attn_tx[0] && rise[TXC_BASE])
        |=> transmit_data_out[0] == $past(s3_reg[TXD_BASE]))
        else $error("bypass data not passed");
    AST_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_clr && limit_reg[0]) |=> (!limit_reg[0] && rvalid && rdata[0]))
        else $error("limit flag not cleared by read");
endmodule : jitter_attenuator_fifo
`default_nettype wire

/* File: line_source.sv */
`default_nettype none
// ====================================
// Framer-side line source, 12 aclk per line bit
module line_source (
    input  wire logic aclk,
    input  wire logic run,
    output var logic  lclk,
    output var logic  ldata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]  ph  = 3'h0;
    logic [15:0] pat = 16'hB3C5;
    initial lclk = 1'b0;
    initial ldata = 1'b0;
    // Clock rests low between frames; idle data toggles so a stale bit never looks valid
    always @(posedge aclk) begin
        ph <= (run && ph != 3'h5) ? ph + 3'h1 : 3'h0;
        lclk <= run ? lclk ^ (ph == 3'h5) : 1'b0;
        if (!run) begin
            ldata <= ~ldata;
        end else if (ph == 3'h5 && lclk) begin
            ldata <= pat[15];
            pat <= {pat[14:0], pat[15]};
        end
    end
endmodule : line_source
`default_nettype wire

/* File: tb.sv */
`default_nettype none
`define CHK(g, e) check((g), (e))
// ====================================
// Top-level bench
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import jitter_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, run, lclk, ldata;
    logic arvalid, arready, rvalid, rready, irq, host_mode_pin, jitter_path_select_pin;
    logic store_depth_select_low_pin, store_depth_select_high_pin, sent;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  wstrb, tx_on, dj_on, transmit_path_clock, receive_path_clock, dejittered_clock;
    logic [3:0]  transmit_data_in, receive_data_in, transmit_data_out, receive_data_out;
    int          err_total, compares;
    // Line routing: one source feeds whichever clocks the scenario enables
    assign transmit_path_clock = {4{lclk}} & tx_on;
    assign receive_path_clock  = {4{lclk}} & ~tx_on;
    assign dejittered_clock    = {4{lclk}} & dj_on;
    assign transmit_data_in    = {4{ldata}};
    assign receive_data_in     = {4{ldata}};
    jitter_attenuator_fifo jitter_attenuator_fifo_inst (.*);
    line_source line_source_inst (.*);
    // Clock, 4 ns period
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // ====================================
    // Bus and compare helpers; sampling at the falling edge avoids edge races
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        @(posedge aclk);
        {aw, w} = 2'h3;
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        while (aw | w) begin
            @(negedge aclk);
            {aw, w} = {aw & !awready, w & !wready};
            @(posedge aclk);
            {awvalid, wvalid} <= {aw, w};
        end
        do @(negedge aclk); while (!bvalid);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        {d, r} = {rdata, rresp};
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axr
    task automatic pulses(input int n);
        @(posedge aclk);
        run <= 1'b1;
        repeat (n) @(posedge lclk);
        // Idle data toggles afterwards, so keep the bit that stood at the last rise
        sent = ldata;
        @(posedge aclk);
        run <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : pulses
    task automatic lim(input logic e);
        axr(ADDR_LIMIT, rd, rs);
        `CHK(rd[0], e);
    endtask : lim
    // ====================================
    // Scenarios
    task automatic t_regs;
        axr(ADDR_INT_ENABLE, rd, rs);
        `CHK(rd, INT_EN_RESET);
        axr(8'h18, rd, rs);
        `CHK(rs, RESP_SLVERR);
        axw(ADDR_STATE, 32'h0000_000F, rs);
        `CHK(rs, RESP_SLVERR);
    endtask : t_regs
    task automatic t_hw;
        for (int p = 0; p < 4; p++) begin
            {jitter_path_select_pin, store_depth_select_high_pin, store_depth_select_low_pin}
                <= {p[0], p[1], !p[1]};
            tx_on <= p[0] ? 4'h0 : 4'hF;
            repeat (8) @(posedge aclk);
            axr(ADDR_STATE, rd, rs);
            `CHK(rd, {16'h0000, {4{1'b0, p[1], !p[1], p[0]}}});
            pulses(1);
            `CHK(p[0] ? receive_data_out : transmit_data_out, {4{sent}});
        end
    endtask : t_hw
    task automatic t_limit;
        host_mode_pin <= 1'b1;
        axw(ADDR_CTRL, 32'h0000_6521, rs);
        axr(ADDR_STATE, rd, rs);
        `CHK(rd, 32'h8000_6521);
        axw(ADDR_CTRL, 32'h0000_0003, rs);
        axw(ADDR_INT_ENABLE, 32'h0000_0001, rs);
        {tx_on, dj_on} <= 8'h10;
        pulses(5);
        lim(1'b0);
        pulses(1);
        lim(1'b1);
        `CHK(irq, 1'b1);
        lim(1'b0);
        {tx_on, dj_on} <= 8'h01;
        pulses(5);
        lim(1'b0);
        pulses(1);
        lim(1'b1);
        axw(ADDR_INT_CLEAR, 32'h0000_0001, rs);
        `CHK(irq, 1'b0);
    endtask : t_limit
    task automatic close_out;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, run, awaddr, araddr, wdata} = '0;
        {host_mode_pin, jitter_path_select_pin, tx_on, dj_on} = '0;
        {store_depth_select_low_pin, store_depth_select_high_pin, aresetn} = '0;
        {wstrb, err_total, compares} = {4'hF, 64'h0};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_hw();
        t_limit();
        close_out();
    end
    // Watchdog, well beyond the few hundred cycles needed
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        close_out();
    end
endmodule : tb
`default_nettype wire
